// ==== rtl/twl_port.sv ====
// Purpose: Three-wire write port, latches, enable, overload, lock detect, observation mux
// Assumes: Serial pins much slower than clk; each level held at least 3 clk periods
// Notes: Registers readable over AHB-Lite, zero wait states, always OKAY
// What this block does
// - Shift data in on each shift-clock rise
// - Two low bits select the target latch
// - Load strobe rise copies word to one latch
// - Chip enable low powers down the device
// - Overload rise drops receive gain 6 dB, floored at code 0
// - Observation shows lock, oscillator or reference
// - Three-bit control latch field picks observation
// - Normal: three good cycles set lock
// - Precise: five good cycles, lose above 25 ns
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
module twl_port
  import twl_pkg::*;
#(
  parameter int ERR_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk_pin,
  input wire logic sdata_pin,
  input wire logic latch_load_strobe_alias,
  input wire logic ce_pin,
  input wire logic adc_overload_gain_drop,
  input wire logic osc_div_pin,
  input wire logic ref_div_pin,
  input wire logic pd_valid,
  input wire logic [ERR_W-1:0] pd_error_ns,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic observation_output,
  output logic device_enable,
  output logic lock_detect,
  output logic [2:0] rx_gain_code
);
  // Pin synchronisers: stage one feeds only stage two
  logic [6:0] s1_r, s2_r, s3_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 7'h00;
      s2_r <= 7'h00;
      s3_r <= 7'h00;
    end else begin
      s1_r <= {ref_div_pin, osc_div_pin, adc_overload_gain_drop, ce_pin,
               latch_load_strobe_alias, sdata_pin, sclk_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic sclk_rise, sdata_s, le_rise, ce_s, ovf_rise, osc_s, ref_s;
  assign sclk_rise = s2_r[0] & ~s3_r[0];
  assign sdata_s = s2_r[1];
  assign le_rise = s2_r[2] & ~s3_r[2];
  assign ce_s = s2_r[3];
  assign ovf_rise = s2_r[4] & ~s3_r[4];
  assign osc_s = s2_r[5];
  assign ref_s = s2_r[6];

  // Serial shift register and the four latches
  logic [WORD_W-1:0] shift_r, shift_nxt;
  logic [3:0][WORD_W-1:0] latch_r, latch_nxt;
  logic [CNT_W-1:0] load_cnt_r, load_cnt_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic sen, load_now;
  assign sen = ctrl_r[CTRL_SEN_BIT];
  assign load_now = le_rise & sen;
  always_comb begin
    shift_nxt = shift_r;
    latch_nxt = latch_r;
    load_cnt_nxt = load_cnt_r;
    if (load_now) begin
      // Word as it stood before this cycle's shift; only one latch changes
      latch_nxt[shift_r[1:0]] = shift_r;
      load_cnt_nxt = load_cnt_r + CNT_W'(1);
    end
    if (sclk_rise && sen) begin
      shift_nxt = {shift_r[WORD_W-2:0], sdata_s};
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= '0;
      latch_r <= '0;
      load_cnt_r <= '0;
    end else begin
      shift_r <= shift_nxt;
      latch_r <= latch_nxt;
      load_cnt_r <= load_cnt_nxt;
    end
  end

  // Enable, receive gain, lock detect and observation
  logic en_r, en_nxt, lock_r, lock_nxt, obs_r, obs_nxt, lock_precision_bit;
  logic [2:0] gain_r, gain_nxt, lock_cnt_r, lock_cnt_nxt, need, obs_sel;
  logic err_good, err_bad;
  assign lock_precision_bit = latch_r[LATCH_RCNT][RCNT_LDP_BIT];
  assign need = lock_precision_bit ? LOCK_CNT_PRECISE : LOCK_CNT_NORMAL;
  assign obs_sel = latch_r[LATCH_CTRL][CTRL_OBS_LSB +: 3];
  assign err_good = pd_error_ns < ERR_W'(LOCK_SET_NS);
  assign err_bad = pd_error_ns > ERR_W'(LOCK_LOSE_NS);
  always_comb begin
    en_nxt = ce_s & ~latch_r[LATCH_CTRL][CTRL_PD_BIT];
    gain_nxt = gain_r;
    if (load_now && shift_r[1:0] == LATCH_RX) begin
      gain_nxt = shift_r[RX_GAIN_LSB +: 3];
    end
    if (ovf_rise) begin
      // Two 3 dB steps, floored at the lowest setting
      gain_nxt = (gain_nxt >= GAIN_DROP_STEPS) ? gain_nxt - GAIN_DROP_STEPS : 3'h0;
    end
    lock_cnt_nxt = lock_cnt_r;
    lock_nxt = lock_r;
    if (!en_r) begin
      lock_cnt_nxt = 3'h0;
      lock_nxt = 1'b0;
    end else if (pd_valid) begin
      if (err_good) begin
        lock_cnt_nxt = (lock_cnt_r == 3'h7) ? 3'h7 : lock_cnt_r + 3'h1;
        if (lock_cnt_nxt >= need) begin
          lock_nxt = 1'b1;
        end
      end else begin
        lock_cnt_nxt = 3'h0;
        if (!lock_precision_bit || err_bad) begin
          lock_nxt = 1'b0;
        end
      end
    end
    obs_nxt = 1'b0;
    if (en_r) begin
      unique case (obs_sel)
        OBS_LOCK: obs_nxt = lock_r;
        OBS_OSC: obs_nxt = osc_s;
        OBS_REF: obs_nxt = ref_s;
        OBS_HIGH: obs_nxt = 1'b1;
        default: obs_nxt = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_r <= 1'b0;
      gain_r <= 3'h0;
      lock_cnt_r <= 3'h0;
      lock_r <= 1'b0;
      obs_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      gain_r <= gain_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      lock_r <= lock_nxt;
      obs_r <= obs_nxt;
    end
  end

  assign observation_output = obs_r;
  assign device_enable = en_r;
  assign lock_detect = lock_r;
  assign rx_gain_code = gain_r;

  // Bus read decode, shared by address phase
  function automatic logic [31:0] rd_mux(input logic [31:0] a, input logic [3:0][WORD_W-1:0] l,
                                         input logic [31:0] st, input logic [31:0] c);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[31:4] == 28'h000_0000 && a[1:0] == 2'h0) begin
      v = {8'h00, l[a[3:2]]};
    end else if (a == {24'h00_0000, ADDR_STATUS}) begin
      v = st;
    end else if (a == {24'h00_0000, ADDR_CTRL}) begin
      v = c;
    end
    return v;
  endfunction

  // AHB-Lite slave: zero wait, registered read data
  logic [31:0] status, hrdata_r, hrdata_nxt;
  logic wr_pend_r, wr_pend_nxt, rdy_r, resp_r, addr_ph;
  always_comb begin
    status = 32'h0000_0000;
    status[ST_CE_BIT] = ce_s;
    status[ST_LOCK_BIT] = lock_r;
    status[ST_EN_BIT] = en_r;
    status[ST_GAIN_LSB +: 3] = gain_r;
    status[ST_CNT_LSB +: CNT_W] = load_cnt_r;
  end
  assign addr_ph = hsel & htrans[1] & hready;
  always_comb begin
    hrdata_nxt = hrdata_r;
    wr_pend_nxt = 1'b0;
    ctrl_nxt = ctrl_r;
    if (wr_pend_r) begin
      ctrl_nxt = hwdata & CTRL_RST;
    end
    if (addr_ph) begin
      wr_pend_nxt = hwrite && haddr == {24'h00_0000, ADDR_CTRL};
      // Forward a CTRL write still in its data phase, so a back-to-back read sees it
      hrdata_nxt = hwrite ? 32'h0000_0000 : rd_mux(haddr, latch_r, status, ctrl_nxt);
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata_r <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      ctrl_r <= CTRL_RST;
      rdy_r <= 1'b1;
      resp_r <= 1'b0;
    end else begin
      hrdata_r <= hrdata_nxt;
      wr_pend_r <= wr_pend_nxt;
      ctrl_r <= ctrl_nxt;
      rdy_r <= 1'b1;
      resp_r <= 1'b0;
    end
  end
  // Bus outputs, all registered
  assign hrdata = hrdata_r;
  assign hreadyout = rdy_r;
  assign hresp = resp_r; // Always OKAY, still from a flop

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_SHIFT_IN: assert property (sclk_rise && sen |=> shift_r == {$past(shift_r[WORD_W-2:0]), $past(sdata_s)})
    else $error("shift register did not take the sampled bit");
  AST_LOAD_SEL: assert property (load_now |=> latch_r[$past(shift_r[1:0])] == $past(shift_r))
    else $error("selected latch did not load the word");
  AST_LATCH_KEEP: assert property (!load_now |=> $stable(latch_r))
    else $error("latch changed without a load");
  AST_CE_OFF: assert property (!ce_s |=> !en_r ##1 !obs_r)
    else $error("device stayed enabled with chip enable low");
  AST_GAIN_DROP: assert property (ovf_rise && !(load_now && shift_r[1:0] == LATCH_RX) |=>
      gain_r == (($past(gain_r) >= GAIN_DROP_STEPS) ? $past(gain_r) - GAIN_DROP_STEPS : 3'h0))
    else $error("overload did not drop the gain by two steps");
  AST_OBS_LOCK: assert property (en_r && obs_sel == OBS_LOCK && $stable(obs_sel) |=> obs_r == $past(lock_r))
    else $error("observation output does not follow lock detect");
  AST_LOCK_SET: assert property ($rose(lock_r) |-> lock_cnt_r >= $past(need))
    else $error("lock asserted before enough good cycles");
  AST_LOCK_HOLD: assert property (lock_r && lock_precision_bit && en_r && pd_valid && !err_bad |=> lock_r)
    else $error("precise lock dropped without a large error");
  AST_LOCK_DROP: assert property (lock_r && !lock_precision_bit && pd_valid && !err_good |=> !lock_r)
    else $error("normal lock held after a bad cycle");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered an error");

  // Serial shift and latch checks
  AST_SHIFT_HOLD: assert property (!(sclk_rise && sen) |=> $stable(shift_r))
    else $error("shift register moved without a shift clock rise");
  AST_CTRL_KEEP: assert property (load_now && shift_r[1:0] != LATCH_CTRL |=> $stable(latch_r[LATCH_CTRL]))
    else $error("control latch changed on a load for another latch");
  AST_RX_KEEP: assert property (load_now && shift_r[1:0] != LATCH_RX |=> $stable(latch_r[LATCH_RX]))
    else $error("receive latch changed on a load for another latch");
  AST_SEN_OFF: assert property (!sen |=> $stable(shift_r) && $stable(latch_r))
    else $error("serial port acted while switched off");
  AST_LOAD_COUNT: assert property (load_now |=> load_cnt_r == $past(load_cnt_r) + CNT_W'(1))
    else $error("load counter did not count the load");
  AST_GAIN_LOAD: assert property (load_now && shift_r[1:0] == LATCH_RX && !ovf_rise |=>
      gain_r == $past(shift_r[RX_GAIN_LSB +: 3]))
    else $error("receive gain did not follow the loaded word");

  // Enable and observation checks
  AST_EN_ON: assert property (ce_s && !latch_r[LATCH_CTRL][CTRL_PD_BIT] |=> en_r)
    else $error("device stayed off with chip enable high");
  AST_OBS_OFF: assert property (!en_r |=> !obs_r)
    else $error("observation output active while powered down");
  AST_OBS_OSC: assert property (en_r && obs_sel == OBS_OSC |=> obs_r == $past(osc_s))
    else $error("observation output does not follow the oscillator");
  AST_OBS_REF: assert property (en_r && obs_sel == OBS_REF |=> obs_r == $past(ref_s))
    else $error("observation output does not follow the reference");

  // Lock detect checks
  AST_LOCK_OFF: assert property (!en_r |=> !lock_r && lock_cnt_r == 3'h0)
    else $error("lock state kept while powered down");
  AST_LOCK_THIRD: assert property (en_r && !lock_precision_bit && pd_valid && err_good && lock_cnt_r == 3'h2 |=> lock_r)
    else $error("normal lock not set on the third good cycle");
  AST_LOCK_EARLY: assert property (en_r && lock_precision_bit && pd_valid && !lock_r && lock_cnt_r < 3'h4 |=> !lock_r)
    else $error("precise lock set before five good cycles");

  // Bus checks
  AST_CTRL_WRITE: assert property (wr_pend_r |=> ctrl_r == $past(hwdata & CTRL_RST))
    else $error("control register did not take the written word");
  AST_WRITE_ZERO: assert property (addr_ph && hwrite |=> hrdata == 32'h0000_0000)
    else $error("write transfer returned read data");

  // Scenario covers
  COV_LOAD_CTRL: cover property (load_now && shift_r[1:0] == LATCH_CTRL);
  COV_LOCK_RISE: cover property ($rose(lock_r));
  COV_OVF_DROP: cover property (ovf_rise && gain_r >= GAIN_DROP_STEPS);
  COV_OBS_OSC: cover property (en_r && obs_sel == OBS_OSC && obs_r);
  COV_PRECISE_LOCK: cover property ($rose(lock_r) && lock_precision_bit);
endmodule

// ==== rtl/twl_pkg.sv ====
// Purpose: Shared constants for the three-wire latch load port
// Assumes: 24-bit serial words, two selector bits at the bottom
// Notes: Latch field positions and bus offsets are block-local
package twl_pkg;
  // Serial word and latch selection
  localparam int WORD_W = 24;
  localparam logic [1:0] LATCH_RX = 2'h0;
  localparam logic [1:0] LATCH_TX = 2'h1;
  localparam logic [1:0] LATCH_RCNT = 2'h2;
  localparam logic [1:0] LATCH_CTRL = 2'h3;

  // Field positions inside the latches
  localparam int CTRL_OBS_LSB = 2;
  localparam int CTRL_PD_BIT = 5;
  localparam int RCNT_LDP_BIT = 23;
  localparam int RX_GAIN_LSB = 2;

  // Observation select codes
  localparam logic [2:0] OBS_LOW = 3'h0;
  localparam logic [2:0] OBS_LOCK = 3'h1;
  localparam logic [2:0] OBS_OSC = 3'h2;
  localparam logic [2:0] OBS_REF = 3'h3;
  localparam logic [2:0] OBS_HIGH = 3'h4;

  // Digital lock detect thresholds, in ns of phase error and in good cycles
  localparam int LOCK_SET_NS = 15;
  localparam int LOCK_LOSE_NS = 25;
  localparam logic [2:0] LOCK_CNT_NORMAL = 3'h3;
  localparam logic [2:0] LOCK_CNT_PRECISE = 3'h5;

  // Receive gain in 3 dB steps, overload drop of 6 dB, floored at code 0
  localparam int GAIN_STEP_DB = 3;
  localparam int GAIN_DROP_DB = 6;
  localparam logic [2:0] GAIN_DROP_STEPS = 3'(GAIN_DROP_DB / GAIN_STEP_DB);

  // Bus map, byte addresses
  localparam logic [7:0] ADDR_LATCH0 = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_SEN_BIT = 0;

  // Status register fields
  localparam int ST_CE_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_EN_BIT = 2;
  localparam int ST_GAIN_LSB = 4;
  localparam int ST_CNT_LSB = 8;
endpackage

// ==== verification/twl_host.sv ====
// Purpose: Host model driving the three-wire write port
// Assumes: Every pin level is held for at least 4 clk periods
// Notes: Shift clock idles low between words
module twl_host (
  input wire logic clk,
  output logic sclk,
  output logic sdata,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle pin levels at time zero
  initial begin
    sclk = 1'h0;
    sdata = 1'h0;
    strobe = 1'h0;
  end

  // Shift one word out MSB first, then pulse the load strobe
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      sdata <= w[i];
      repeat (4) @(posedge clk);
      sclk <= 1'h1;
      repeat (4) @(posedge clk);
      sclk <= 1'h0;
    end
    sdata <= ~w[0]; // Released line shows no stale bit
    repeat (4) @(posedge clk);
    strobe <= 1'h1;
    repeat (4) @(posedge clk);
    strobe <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== verification/three_wire_latch_load_port_tb.sv ====
// Purpose: Self-checking bench for the three-wire latch load port
// Assumes: Zero-wait bus slave, host model paces the serial pins
// Notes: Outputs are sampled at clock edges, well after their cause
module three_wire_latch_load_port_tb;
  import twl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, ce = 1, ovl = 0, osc = 0, refd = 0, pdv = 0, hsel = 0, hwrite = 0;
  logic [7:0] pde = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic sclk, sdata, strb, hrdy, hresp, obs, en, lock;
  logic [2:0] gain;
  logic [23:0] wv [4] = '{24'hA5_C014, 24'h5A_3C01, 24'h12_3402, 24'h00_0007};
  int miscompares = 0, checks = 0;

  always #20 clk = ~clk;

  twl_host twl_host_i (.clk(clk), .sclk(sclk), .sdata(sdata), .strobe(strb));
  twl_port twl_port_i (.clk(clk), .nrst(nrst), .sclk_pin(sclk), .sdata_pin(sdata),
    .latch_load_strobe_alias(strb), .ce_pin(ce), .adc_overload_gain_drop(ovl), .osc_div_pin(osc),
    .ref_div_pin(refd), .pd_valid(pdv), .pd_error_ns(pde), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata),
    .hresp(hresp), .observation_output(obs), .device_enable(en), .lock_detect(lock), .rx_gain_code(gain));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One single transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hrdy !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'h1);
    rd = hrdata;
  endtask

  // One phase detector result
  task automatic pd(input logic [7:0] e);
    pdv <= 1'h1;
    pde <= e;
    @(posedge clk);
    pdv <= 1'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    bus(1'h0, ADDR_CTRL, 32'h0000_0000);
    chk(rd, CTRL_RST);
    bus(1'h0, 8'h18, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({gain, lock, obs}, 32'h0000_0000);
    chk({hrdy, hresp}, 32'h0000_0002);
  endtask

  task automatic t_latches;
    for (int i = 0; i < 4; i++) twl_host_i.send(wv[i]);
    for (int i = 0; i < 4; i++) begin
      bus(1'h0, 8'(4 * i), 32'h0000_0000);
      chk(rd, {8'h00, wv[i]});
    end
    chk(gain, 32'h0000_0005);
    bus(1'h0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0455);
  endtask

  task automatic t_gain;
    for (int i = 0; i < 3; i++) begin
      ovl <= 1'h1;
      repeat (4) @(posedge clk);
      ovl <= 1'h0;
      repeat (4) @(posedge clk);
      chk(gain, (i < 2) ? 32'(3 - 2 * i) : 32'h0000_0000);
    end
  endtask

  task automatic t_lock;
    repeat (2) pd(8'h0A);
    chk(lock, 1'h0);
    pd(8'h0A);
    chk(lock, 1'h1);
    repeat (3) @(posedge clk);
    chk(obs, 1'h1);
    pd(8'h0F);
    chk(lock, 1'h0);
    twl_host_i.send(24'h80_0002);
    repeat (4) pd(8'h0A);
    chk(lock, 1'h0);
    pd(8'h0A);
    chk(lock, 1'h1);
    pd(8'h19);
    chk(lock, 1'h1);
    pd(8'h1A);
    chk(lock, 1'h0);
  endtask

  task automatic t_obs;
    for (int m = 0; m < 5; m++) begin
      twl_host_i.send({19'h0_0000, 3'(m), 2'h3});
      // Oscillator and reference opposite, so each source is told apart
      for (int k = 0; k < 2; k++) begin
        osc <= k[0];
        refd <= ~k[0];
        repeat (5) @(posedge clk);
        chk(obs, m == 4 || (m == 2 && k == 1) || (m == 3 && k == 0));
      end
    end
  endtask

  task automatic t_enable;
    chk(en, 1'h1);
    ce <= 1'h0;
    repeat (5) @(posedge clk);
    chk(en, 1'h0);
    ce <= 1'h1;
    twl_host_i.send(24'h00_0023);
    chk(en, 1'h0);
    twl_host_i.send(24'h00_0003);
    chk(en, 1'h1);
  endtask

  // Serial port switched off: a load must not reach the latch
  task automatic t_refuse;
    bus(1'h1, ADDR_CTRL, 32'h0000_0000);
    bus(1'h0, ADDR_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    twl_host_i.send(24'h00_0018);
    bus(1'h0, ADDR_LATCH0, 32'h0000_0000);
    chk(rd, 32'h00A5_C014);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_reset();
    t_latches();
    t_gain();
    t_lock();
    t_obs();
    t_enable();
    t_refuse();
    give_verdict();
  end

  // Watchdog
  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
